/* src/pds_pkg.sv */
/*
 package for the pressing / pause / direct-start sequencer: register map,
 field layout, timing and state type. assumes a 40 MHz clk_sys.
*/
package pds_pkg;
   localparam int ENTRY_COUNT = 3;
   // register map, byte addresses; entry n occupies 8'h00 + n*16
   localparam logic [7:0] OFF_TARGET = 8'h00;
   localparam logic [7:0] OFF_WIDTH = 8'h04;
   localparam logic [7:0] OFF_PROFILE = 8'h08;
   localparam logic [7:0] OFF_PRESS = 8'h0c;
   localparam logic [7:0] OFF_CTRL = 8'h30;
   localparam logic [7:0] OFF_STATUS = 8'h34;
   localparam logic [7:0] OFF_POSITION = 8'h38;
   localparam int ENTRY_SEL_LSB = 4;
   localparam logic [3:0] FIELD_MASK = 4'hc;
   // profile word: speed [15:0], accel [31:16]
   localparam int SPEED_LSB = 0;
   localparam int ACCEL_LSB = 16;
   // press word: percent [7:0], incremental [8], decel [31:16]
   localparam int PCT_LSB = 0;
   localparam int INCR_BIT = 8;
   localparam int DECEL_LSB = 16;
   // control word: servo on [0]
   localparam int SERVO_BIT = 0;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_PERIOD_US = 1000;
   localparam int TICK_CYCLES_DEFAULT = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
   localparam int PRESS_JUDGE_MS = 255;
   localparam logic [7:0] JUDGE_TICKS = 8'(PRESS_JUDGE_MS * 1000 / TICK_PERIOD_US);
   // motion constants in position units per tick; full torque in percent
   localparam logic [15:0] HOME_SPEED = 16'h0010;
   localparam logic [15:0] PRESS_SPEED = 16'h0004;
   localparam logic [15:0] MIN_SPEED = 16'h0001;
   localparam logic [7:0] FULL_TORQUE = 8'h64;
   typedef enum logic [2:0] {
      ST_IDLE, ST_HOMING, ST_MOVE, ST_PRESS, ST_DONE, ST_MISS
   } pds_state_t;
endpackage

/* src/pds_press_if.sv */
/*
 interface between the sequencer and its pressing judge.
 assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
interface pds_press_if;
   logic tick;
   logic clear;
   logic active;
   logic currentHigh;
   logic reached;
   modport judge (input tick, input clear, input active, input currentHigh, output reached);
   modport seq (output tick, output clear, output active, output currentHigh, input reached);
endinterface

/* src/pds_press_judge.sv */
/*
 pressing completion judge: up/down time accumulator on the tick.
 assumes tick is one clk_sys cycle per millisecond.
*/
`timescale 1ns/1ps
module pds_press_judge (
   input wire logic clk_sys,
   input wire logic rst,
   pds_press_if.judge pj
);
   logic [7:0] acc_reg;
   logic reached_reg;

   always_ff @(posedge clk_sys) begin
      if (rst || pj.clear) begin
         acc_reg <= 8'h00;
      end else if (pj.tick && pj.active) begin
         if (pj.currentHigh && acc_reg != pds_pkg::JUDGE_TICKS) begin
            acc_reg <= acc_reg + 8'h01;
         end else if (!pj.currentHigh && acc_reg != 8'h00) begin
            acc_reg <= acc_reg - 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || pj.clear) begin
         reached_reg <= 1'b0;
      end else begin
         reached_reg <= pj.active && acc_reg == pds_pkg::JUDGE_TICKS;
      end
   end

   assign pj.reached = reached_reg;

   chk_acc_floor: assert property (@(posedge clk_sys) disable iff (rst)
      (pj.tick && pj.active && !pj.currentHigh && acc_reg == 8'h00 && !pj.clear)
      |=> acc_reg == 8'h00)
      else $error("press accumulator went below zero");
   chk_judge_reach: assert property (@(posedge clk_sys) disable iff (rst)
      reached_reg |-> $past(acc_reg) == pds_pkg::JUDGE_TICKS)
      else $error("press judged complete before the time threshold");
endmodule // pds_press_judge

/* src/pds_sequencer.sv */
/*
 pressing / tension / multi-step / pause / direct-start sequencer with apb registers.
 assumes start, pause and home sensor pins are asynchronous; load current comes
 from the current loop on clk_sys.
*/
// Added by the designer: the APB interface to the registers and the register addresses.
// Function
// - press completes when time above percent minus time below reaches 255 ms
// - completion is flagged on the current-time condition even if still moving
// - pressing limits torque to the entry percent and judges against it
// - negative width means tension: target is start point, magnitude is pull
// - tension approaches at full torque, then pulls negative under entry torque
// - tension or press with no stop travels full width, no completion flag
// - force changes only while pressing; next stronger entry after completion
// - pause input low-active; release during motion other than homing decelerates with entry decel
// - completion stays low while paused
// - pause reassert resumes remaining travel with entry acceleration
// - pause release in completed state drops the completion output
// - one start input per entry 0, 1, 2; one alone runs that entry
// - one completion output per entry, the finished entry's one asserts
// - entries may be absolute, pressing or incremental pitch feed
// - no speed change while moving: starts ignored until the move ends
// - first start after power-up homes before running the entry
// - entry done asserts inside width, holds until new start or servo off
`timescale 1ns/1ps
module pds_sequencer #(
   parameter int TICK_CYCLES = pds_pkg::TICK_CYCLES_DEFAULT
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic entry0_start,
   input wire logic entry1_start,
   input wire logic entry2_start,
   input wire logic pause_hold_n,
   input wire logic homeSensor,
   input wire logic [7:0] loadCurrentPct,
   output logic positioning_complete,
   output logic entry0_done,
   output logic entry1_done,
   output logic entry2_done,
   output logic [31:0] motorPosition,
   output logic [15:0] motorVelocity,
   output logic [7:0] torqueLimitPct
);
   localparam int N = pds_pkg::ENTRY_COUNT;

   pds_press_if pj ();
   pds_press_judge u_judge (.clk_sys(clk_sys), .rst(rst), .pj(pj));

   logic [31:0] target_reg [N];
   logic [31:0] width_reg [N];
   logic [31:0] profile_reg [N];
   logic [31:0] press_reg [N];
   logic [31:0] ctrl_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic [N-1:0] startMeta_reg, startSync_reg, startPrev_reg;
   logic [1:0] pauseSync_reg, homeSync_reg;
   logic [31:0] tickCount_reg;
   logic tick;
   pds_pkg::pds_state_t state_reg;
   logic homed_reg;
   logic [1:0] entry_reg;
   logic [31:0] pos_reg, goal_reg;
   logic [15:0] velocity_reg;
   logic [N-1:0] done_reg;
   logic complete_reg;

   logic setupPhase, accessWrite;
   logic [1:0] selEntry;
   logic servoOn, paused, moving, canStart;
   logic [N-1:0] startRise;
   logic startAny;
   logic [1:0] startIdx;
   logic [15:0] curSpeed, curAccel, curDecel;
   logic [7:0] curPct;
   logic isPress, isTension, isIncr;
   logic signed [31:0] curWidth;
   logic [31:0] widthMag;
   logic signed [32:0] remWide;
   logic [32:0] absRem;
   logic [31:0] vSq;
   logic [49:0] brakeRoom;
   logic [15:0] velNext;
   logic [31:0] stepLen;
   logic arrived, inWidth;

   // apb slave: zero wait state, read data captured in the setup cycle
   assign setupPhase = psel && !penable;
   assign accessWrite = psel && penable && pwrite;
   assign selEntry = paddr[pds_pkg::ENTRY_SEL_LSB +: 2];
   assign pready = 1'b1;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   generate
      for (genvar e = 0; e < N; e++) begin : g_entry
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               target_reg[e] <= pds_pkg::REG_RESET;
               width_reg[e] <= pds_pkg::REG_RESET;
               profile_reg[e] <= pds_pkg::REG_RESET;
               press_reg[e] <= pds_pkg::REG_RESET;
            end else if (accessWrite && selEntry == 2'(e)) begin
               case ({4'h0, paddr[3:0] & pds_pkg::FIELD_MASK})
                  pds_pkg::OFF_TARGET: target_reg[e] <= pwdata;
                  pds_pkg::OFF_WIDTH: width_reg[e] <= pwdata;
                  pds_pkg::OFF_PROFILE: profile_reg[e] <= pwdata;
                  pds_pkg::OFF_PRESS: press_reg[e] <= pwdata;
                  default: ;
               endcase
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_reg <= pds_pkg::REG_RESET;
      end else if (accessWrite && paddr == pds_pkg::OFF_CTRL) begin
         ctrl_reg <= pwdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (setupPhase) begin
         pslverr_reg <= 1'b0;
         if (paddr[1:0] == 2'h0 && selEntry < 2'(N)) begin
            case ({4'h0, paddr[3:0]})
               pds_pkg::OFF_TARGET: prdata_reg <= target_reg[selEntry];
               pds_pkg::OFF_WIDTH: prdata_reg <= width_reg[selEntry];
               pds_pkg::OFF_PROFILE: prdata_reg <= profile_reg[selEntry];
               default: prdata_reg <= press_reg[selEntry];
            endcase
         end else if (paddr == pds_pkg::OFF_CTRL) begin
            prdata_reg <= ctrl_reg;
         end else if (paddr == pds_pkg::OFF_STATUS) begin
            prdata_reg <= {21'h0, entry_reg, done_reg, complete_reg, paused, homed_reg,
                           state_reg};
         end else if (paddr == pds_pkg::OFF_POSITION) begin
            prdata_reg <= pos_reg;
         end else begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b1;
         end
      end
   end

   // pin synchronisers; the second stage is read, and for the starts also a third stage for edge detection
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         startMeta_reg <= '0;
         startSync_reg <= '0;
         startPrev_reg <= '0;
         pauseSync_reg <= 2'b11; // idle level, so no false pause follows reset
         homeSync_reg <= 2'b00;
      end else begin
         startMeta_reg <= {entry2_start, entry1_start, entry0_start};
         startSync_reg <= startMeta_reg;
         startPrev_reg <= startSync_reg;
         pauseSync_reg <= {pauseSync_reg[0], pause_hold_n};
         homeSync_reg <= {homeSync_reg[0], homeSensor};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || tick) begin
         tickCount_reg <= 32'h0000_0000;
      end else begin
         tickCount_reg <= tickCount_reg + 32'h0000_0001;
      end
   end
   assign tick = tickCount_reg == 32'(TICK_CYCLES - 1);

   // lowest entry wins if the host breaks its one-at-a-time interlock
   assign startRise = startSync_reg & ~startPrev_reg;
   assign startAny = |startRise;
   assign startIdx = startRise[0] ? 2'd0 : (startRise[1] ? 2'd1 : 2'd2);
   assign servoOn = ctrl_reg[pds_pkg::SERVO_BIT];
   assign paused = !pauseSync_reg[1];
   assign moving = state_reg == pds_pkg::ST_HOMING || state_reg == pds_pkg::ST_MOVE
                   || state_reg == pds_pkg::ST_PRESS;
   assign canStart = servoOn && !moving;

   assign curSpeed = profile_reg[entry_reg][pds_pkg::SPEED_LSB +: 16];
   assign curAccel = profile_reg[entry_reg][pds_pkg::ACCEL_LSB +: 16];
   assign curDecel = press_reg[entry_reg][pds_pkg::DECEL_LSB +: 16];
   assign curPct = press_reg[entry_reg][pds_pkg::PCT_LSB +: 8];
   assign isIncr = press_reg[entry_reg][pds_pkg::INCR_BIT];
   assign curWidth = width_reg[entry_reg];
   assign isPress = curPct != 8'h00;
   assign isTension = isPress && curWidth[31];
   assign widthMag = curWidth[31] ? 32'(-curWidth) : curWidth;

   // motion profile: trapezoid on the tick, braking when v^2 >= 2*decel*remaining
   always_comb begin
      remWide = {goal_reg[31], goal_reg} - {pos_reg[31], pos_reg};
      absRem = remWide[32] ? 33'(-remWide) : 33'(remWide);
      vSq = velocity_reg * velocity_reg;
      brakeRoom = 50'({curDecel, 1'b0}) * 50'(absRem);
      if (state_reg == pds_pkg::ST_HOMING) begin
         velNext = pds_pkg::HOME_SPEED;
      end else if (paused || brakeRoom <= 50'(vSq)) begin
         velNext = velocity_reg > curDecel ? velocity_reg - curDecel : 16'h0000;
         if (!paused && velNext == 16'h0000 && absRem != 33'h0) begin
            velNext = pds_pkg::MIN_SPEED;
         end
      end else begin
         velNext = velocity_reg + curAccel;
         if (velNext > curSpeed || velNext < velocity_reg) begin
            velNext = curSpeed;
         end
         if (state_reg == pds_pkg::ST_PRESS && velNext > pds_pkg::PRESS_SPEED) begin
            velNext = pds_pkg::PRESS_SPEED;
         end
      end
      stepLen = 33'(velNext) > absRem ? absRem[31:0] : 32'(velNext);
      arrived = absRem == 33'h0;
      inWidth = absRem <= 33'(widthMag);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= pds_pkg::ST_IDLE;
         homed_reg <= 1'b0;
         entry_reg <= 2'd0;
         pos_reg <= 32'h0000_0000;
         goal_reg <= 32'h0000_0000;
         velocity_reg <= 16'h0000;
      end else if (!servoOn) begin
         state_reg <= pds_pkg::ST_IDLE;
         velocity_reg <= 16'h0000;
      end else begin
         case (state_reg)
            pds_pkg::ST_IDLE, pds_pkg::ST_DONE, pds_pkg::ST_MISS: begin
               if (startAny) begin
                  entry_reg <= startIdx;
                  if (!homed_reg) begin
                     state_reg <= pds_pkg::ST_HOMING;
                  end else begin
                     state_reg <= pds_pkg::ST_MOVE;
                     goal_reg <= press_reg[startIdx][pds_pkg::INCR_BIT]
                                 ? pos_reg + target_reg[startIdx] : target_reg[startIdx];
                  end
               end
            end
            pds_pkg::ST_HOMING: begin
               if (homeSync_reg[1]) begin
                  pos_reg <= 32'h0000_0000;
                  homed_reg <= 1'b1;
                  velocity_reg <= 16'h0000;
                  state_reg <= pds_pkg::ST_MOVE;
                  goal_reg <= isIncr ? target_reg[entry_reg] : target_reg[entry_reg];
               end else if (tick) begin
                  pos_reg <= pos_reg - 32'(pds_pkg::HOME_SPEED);
               end
            end
            pds_pkg::ST_MOVE, pds_pkg::ST_PRESS: begin
               if (state_reg == pds_pkg::ST_PRESS && pj.reached) begin
                  velocity_reg <= 16'h0000;
                  state_reg <= pds_pkg::ST_DONE;
               end else if (arrived && velocity_reg == 16'h0000 || arrived && tick) begin
                  velocity_reg <= 16'h0000;
                  if (state_reg == pds_pkg::ST_PRESS) begin
                     state_reg <= pds_pkg::ST_MISS;
                  end else if (isPress) begin
                     state_reg <= pds_pkg::ST_PRESS;
                     // tension pulls negative; a plain press pushes negative for a negative goal, positive otherwise
                     goal_reg <= isTension ? pos_reg - widthMag :
                                 (goal_reg[31] ? pos_reg - widthMag : pos_reg + widthMag);
                  end else begin
                     state_reg <= pds_pkg::ST_DONE;
                  end
               end else if (tick) begin
                  velocity_reg <= velNext;
                  pos_reg <= remWide[32] ? pos_reg - stepLen : pos_reg + stepLen;
               end
            end
            default: state_reg <= pds_pkg::ST_IDLE;
         endcase
      end
   end

   // done flags: servo off in the same cycle wins over a set; a start is ignored while moving, where sets happen, so it never clears one
   always_ff @(posedge clk_sys) begin
      if (rst || !servoOn) begin
         done_reg <= '0;
      end else if (startAny && canStart) begin
         done_reg <= '0;
      end else if ((state_reg == pds_pkg::ST_MOVE && !isPress && inWidth && !paused)
                   || (state_reg == pds_pkg::ST_PRESS && pj.reached)) begin
         done_reg <= N'(1) << entry_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || !servoOn) begin
         complete_reg <= 1'b0;
      end else if (startAny && canStart) begin
         complete_reg <= 1'b0;
      end else if ((state_reg == pds_pkg::ST_MOVE && !isPress && inWidth && !paused)
                   || (state_reg == pds_pkg::ST_PRESS && pj.reached)) begin
         complete_reg <= 1'b1;
      end else if (paused) begin
         complete_reg <= 1'b0;
      end
   end

   assign pj.tick = tick;
   assign pj.clear = state_reg != pds_pkg::ST_PRESS;
   assign pj.active = state_reg == pds_pkg::ST_PRESS && !paused;
   assign pj.currentHigh = loadCurrentPct >= curPct;

   assign positioning_complete = complete_reg && !paused;
   assign entry0_done = done_reg[0];
   assign entry1_done = done_reg[1];
   assign entry2_done = done_reg[2];
   assign motorPosition = pos_reg;
   assign motorVelocity = velocity_reg;
   // pressing force stays applied while holding after a press, so a stronger entry can follow
   assign torqueLimitPct = (state_reg == pds_pkg::ST_PRESS
                           || (state_reg == pds_pkg::ST_DONE && isPress))
                           ? curPct : pds_pkg::FULL_TORQUE;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence seq_press_hit;
      state_reg == pds_pkg::ST_PRESS && pj.reached && servoOn;
   endsequence
   sequence seq_pause_slow;
      paused && tick && velocity_reg != 16'h0000 && state_reg == pds_pkg::ST_MOVE && servoOn
         && !arrived && curDecel != 16'h0000;
   endsequence

   chk_press_done: assert property (seq_press_hit |=> complete_reg
      && state_reg == pds_pkg::ST_DONE)
      else $error("press judged but completion not flagged");
   chk_pause_mask: assert property (paused |-> !positioning_complete)
      else $error("completion visible while paused");
   chk_pause_noset: assert property (paused && !complete_reg
      && state_reg != pds_pkg::ST_PRESS |=> !complete_reg)
      else $error("completion set while paused");
   chk_pause_drop: assert property ($fell(pauseSync_reg[1]) && !startAny
      && state_reg != pds_pkg::ST_PRESS |=> !complete_reg)
      else $error("pause release kept completion");
   chk_press_torque: assert property (state_reg == pds_pkg::ST_PRESS
      |-> torqueLimitPct == curPct)
      else $error("pressing torque limit wrong");
   chk_pause_decel: assert property (seq_pause_slow |=>
      velocity_reg < $past(velocity_reg))
      else $error("no deceleration during pause");
   chk_miss_noflag: assert property (state_reg == pds_pkg::ST_PRESS && arrived && tick
      && !pj.reached && servoOn |=> state_reg == pds_pkg::ST_MISS && !complete_reg)
      else $error("missed press flagged complete");
   chk_busy_ignore: assert property (moving && startAny && servoOn
      |=> entry_reg == $past(entry_reg))
      else $error("start accepted during motion");
   chk_home_first: assert property (canStart && startAny && !homed_reg
      |=> state_reg == pds_pkg::ST_HOMING)
      else $error("first start did not home");
   chk_done_onehot: assert property ($onehot0(done_reg))
      else $error("more than one entry done");
   chk_done_hold: assert property (|done_reg && !startAny && servoOn
      |=> done_reg == $past(done_reg))
      else $error("entry done dropped without start or servo off");
endmodule // pds_sequencer

/* verification/pds_host_model.sv */
/*
 host controller model: entry start pins and the pause pin.
 assumes it shares clk_sys with the sequencer and the bench sequences it.
*/
`timescale 1ns/1ps
module pds_host_model (
   input wire logic clk_sys,
   input wire logic [2:0] doneVec,
   output logic [2:0] startVec,
   output logic pause_hold_n
);
   initial begin
      startVec = 3'h0;
      pause_hold_n = 1'b1;
   end
   // raises one entry's start on the next edge, other starts keep their level; prep entry runs before tension
   task automatic press(input int idx);
      @(posedge clk_sys) startVec[idx] <= 1'b1;
   endtask
   // drops the start on the next edge without waiting for that entry's done
   task automatic drop(input int idx);
      @(posedge clk_sys) startVec[idx] <= 1'b0;
   endtask
   // waits for the entry's own done before dropping its start
   task automatic let_go(input int idx);
      while (doneVec[idx] !== 1'b1) @(posedge clk_sys);
      @(posedge clk_sys) startVec[idx] <= 1'b0;
   endtask
   // pause pin is held high in normal running
   task automatic hold(input logic v);
      @(posedge clk_sys) pause_hold_n <= v;
   endtask
endmodule // pds_host_model

/* verification/pds_sequencer_bench.sv */
/*
 self-checking bench for pds_sequencer with apb master, plant and host model.
 assumes the design answers apb with pready and flags done per entry.
*/
`timescale 1ns/1ps
module pds_sequencer_bench;
   localparam int TICK = 4;
   logic clk_sys = 1'b0;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] startVec;
   logic [2:0] doneVec;
   logic pauseHoldN;
   logic homeSensor;
   logic [7:0] loadCurrentPct;
   logic positioning_complete;
   logic [31:0] motorPosition;
   logic [15:0] motorVelocity;
   logic [7:0] torqueLimitPct;
   logic [15:0] rnd = 16'h0025;
   logic pressHot = 1'b0;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   always #12.5 clk_sys = ~clk_sys;
   pds_sequencer #(.TICK_CYCLES(TICK)) pds_sequencer_inst (.clk_sys(clk_sys), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .entry0_start(startVec[0]),
      .entry1_start(startVec[1]), .entry2_start(startVec[2]), .pause_hold_n(pauseHoldN),
      .homeSensor(homeSensor), .loadCurrentPct(loadCurrentPct),
      .positioning_complete(positioning_complete), .entry0_done(doneVec[0]),
      .entry1_done(doneVec[1]), .entry2_done(doneVec[2]), .motorPosition(motorPosition),
      .motorVelocity(motorVelocity), .torqueLimitPct(torqueLimitPct));
   pds_host_model pds_host_model_inst (.clk_sys(clk_sys), .doneVec(doneVec),
      .startVec(startVec), .pause_hold_n(pauseHoldN));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic int absd(input logic [31:0] a, input int b);
      int d = $signed(a) - b;
      return d < 0 ? -d : d;
   endfunction
   // plant: home switch below -20, load noise stays under every nonzero entry percent
   always @(posedge clk_sys) begin
      rnd <= lfsr(rnd);
      cyc <= cyc + 1;
      homeSensor <= $signed(motorPosition) < -20;
      loadCurrentPct <= pressHot ? 8'h32 + {1'b0, rnd[6:0]} : {4'h0, rnd[3:0]};
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys) penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic setEntry(input int n, input int tgt, input int w, input logic [7:0] pct,
         input logic incr);
      wr(8'(n * 16), tgt);
      wr(8'(n * 16 + 4), w);
      wr(8'(n * 16 + 8), 32'h0008_0008);
      wr(8'(n * 16 + 12), {16'h0008, 7'h00, incr, pct});
   endtask
   task automatic waitState(input logic [2:0] s);
      logic [31:0] q;
      logic e;
      for (int n = 0; n < 400; n++) begin
         apb(1'b0, 8'h34, 32'h0, q, e);
         if (q[2:0] === s) break;
      end
      if (q[2:0] !== s) errors++;
   endtask
   // waits for one entry done, keeping the lowest position passed on the way
   task automatic waitDone(input int idx, output int lo);
      lo = 0;
      for (int n = 0; n < 3000 && doneVec[idx] !== 1'b1; n++) begin
         @(posedge clk_sys);
         if ($signed(motorPosition) < lo) lo = $signed(motorPosition);
      end
      if (doneVec[idx] !== 1'b1) errors++;
   endtask
   initial begin
      logic [31:0] q;
      logic e;
      int lo;
      int t0;
      logic [15:0] v;
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check("torque_rst", torqueLimitPct, 8'h64);
      apb(1'b0, 8'h3c, 32'h0, q, e);
      check("unmapped_err", e, 1'b1);
      check("unmapped_data", q, 32'h0);
      setEntry(0, 40, 1, 8'h00, 1'b0);
      setEntry(1, 200, 2, 8'h00, 1'b0);
      setEntry(2, 100, 2000, 8'h32, 1'b0);
      apb(1'b0, 8'h2c, 32'h0, q, e);
      check("press_word", q, {16'h0008, 16'h0032});
      wr(8'h30, 32'h1);
      pds_host_model_inst.press(0);
      waitDone(0, lo);
      check("homed_first", lo < 0, 1'b1);
      check("done_one", doneVec, 3'b001);
      check("pos_win0", absd(motorPosition, 40) <= 1, 1'b1);
      pds_host_model_inst.drop(0);
      repeat (6) @(posedge clk_sys);
      check("done_holds", doneVec, 3'b001);
      pds_host_model_inst.press(1);
      repeat (24) @(posedge clk_sys);
      pds_host_model_inst.hold(1'b0);
      repeat (60) @(posedge clk_sys);
      check("vel_paused", motorVelocity, 16'h0);
      check("positioning_complete_paused", positioning_complete, 1'b0);
      check("short_of", $signed(motorPosition) < 200, 1'b1);
      pds_host_model_inst.hold(1'b1);
      pds_host_model_inst.press(0);
      repeat (4) @(posedge clk_sys);
      pds_host_model_inst.drop(0);
      waitDone(1, lo);
      check("resumed", doneVec, 3'b010);
      check("pos_win1", absd(motorPosition, 200) <= 2, 1'b1);
      pds_host_model_inst.hold(1'b0);
      repeat (4) @(posedge clk_sys);
      pds_host_model_inst.hold(1'b1);
      repeat (4) @(posedge clk_sys);
      check("positioning_complete_drop", positioning_complete, 1'b0);
      pds_host_model_inst.drop(1);
      // tension from 200 down to 150, pulls 20 against no load
      setEntry(0, 150, -20, 8'h1e, 1'b0);
      pds_host_model_inst.press(0);
      repeat (12) @(posedge clk_sys);
      check("approach_torque", torqueLimitPct, 8'h64);
      waitState(3'h3);
      check("pull_torque", torqueLimitPct, 8'h1e);
      waitState(3'h5);
      check("pull_end", $signed(motorPosition), 150 - 20);
      check("miss_flags", {positioning_complete, doneVec}, 4'h0);
      pds_host_model_inst.drop(0);
      pds_host_model_inst.press(2);
      waitState(3'h3);
      pressHot <= 1'b1;
      t0 = cyc;
      v = 16'h0;
      // velocity of the judging cycle: the flag comes while the press still moves
      for (int n = 0; n < 3000 && positioning_complete !== 1'b1; n++) begin
         v = motorVelocity;
         @(posedge clk_sys);
      end
      t0 = cyc - t0;
      check("judge_time", t0 >= 254 * TICK && t0 <= 256 * TICK + 4, 1'b1);
      check("still_moving", v != 16'h0, 1'b1);
      check("press_torque", torqueLimitPct, 8'h32);
      check("press_done", doneVec, 3'b100);
      pressHot <= 1'b0;
      pds_host_model_inst.let_go(2);
      // pitch feed: entry 1 becomes a relative step of 16 from where the press stopped
      setEntry(1, 16, 2, 8'h00, 1'b1);
      t0 = $signed(motorPosition);
      pds_host_model_inst.press(1);
      waitDone(1, lo);
      check("pitch_feed", absd(motorPosition, t0 + 16) <= 2, 1'b1);
      close_out();
   end
   initial begin
      repeat (40000) @(posedge clk_sys);
      errors++;
      close_out();
   end
endmodule // pds_sequencer_bench
